/* File: hdl/bop_pkg.sv */
package bop_pkg;
    // register map
    localparam logic [7:0]  BOP_OFFSET       = 8'h20;
    localparam logic [7:0]  BOP_ADDR_MASK    = 8'hFC;
    // field positions
    localparam int          BOP_IRMC_BIT     = 31;
    localparam int          BOP_CMC_BIT      = 30;
    localparam int          BOP_ISC_BIT      = 29;
    localparam int          BOP_BMC_BIT      = 28;
    localparam int          BOP_PMC_BIT      = 27;
    localparam int          BOP_ACC_LSB      = 16;
    localparam int          BOP_REQ_LSB      = 12;
    localparam int          BOP_GEN_LSB      = 6;
    localparam int          BOP_SPD_LSB      = 0;
    // reset values and constants
    localparam logic [3:0]  BOP_REQ_DEFAULT  = 4'hA;
    localparam logic [3:0]  BOP_REQ_MIN      = 4'h8;
    localparam logic [2:0]  BOP_SPD_CODE     = 3'h2;
    localparam logic [4:0]  BOP_CAPS_DEFAULT = 5'h00;
    localparam logic [7:0]  BOP_ACC_DEFAULT  = 8'h00;
    localparam logic [1:0]  BOP_GEN_DEFAULT  = 2'h0;
    localparam logic [1:0]  BOP_GEN_STEP     = 2'h1;
    localparam logic [31:0] BOP_SIZE_ONE     = 32'h0000_0001;

    // host register access carrier
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } bop_req_t;
endpackage

/* File: hdl/bop_options.sv */
`timescale 1ns/100ps
// Summary of operation
// - register at offset 20h, second bus info quadlet
// - reserved bits read zero, writes ignored
// - bits 30..28 plain capability storage
// - bit 27 advertises power management support
// - bits 23..16 store clock accuracy verbatim
// - request size is two to field plus one
// - hardware reset loads 2048 byte code
// - oversize block write may earn type error
// - generation advances after ROM change
// - link speed reads constant 010
// - size field reset only by hardware or global reset
module bop_options (
    input  wire logic             ref_clk_in,
    input  wire logic             nrst_in,
    input  wire logic             global_power_on_reset_in,
    input  wire logic             soft_reset_in,
    input  wire bop_pkg::bop_req_t req_in,
    input  wire logic             link_active_enable_in,
    input  wire logic             rom_changed_in,
    input  wire logic             bus_reset_in,
    input  wire logic             blk_wr_in,
    input  wire logic [15:0]      blk_len_in,
    output logic [31:0]           rdata_out,
    output logic                  ack_type_error_out,
    output logic [31:0]           rom_quadlet_out
);
    import bop_pkg::*;

    logic [4:0]  caps;
    logic [7:0]  accuracy;
    logic [3:0]  req_size;
    logic [1:0]  generation;
    logic        rom_dirty;
    logic        hit_wr;
    logic        hard_rst;
    logic [31:0] cur_word;

    ////////////////////////////////////////////////////////////////////
    // address decode; word address matched, byte lanes ignored
    function automatic logic bop_hit(input logic [7:0] addr);
        bop_hit = (addr & BOP_ADDR_MASK) == BOP_OFFSET;
    endfunction

    assign hit_wr   = req_in.wr && bop_hit(req_in.addr);
    assign hard_rst = !nrst_in || global_power_on_reset_in;

    // bytes allowed by a request-size code; the five-bit sum keeps
    // code Fh at 64 KiB instead of wrapping to a one-byte limit
    function automatic logic [31:0] bop_max_bytes(input logic [3:0] code);
        bop_max_bytes = BOP_SIZE_ONE << ({1'b0, code} + 5'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // capability flags; soft reset clears them too
    always_ff @(posedge ref_clk_in) begin
        if (hard_rst || soft_reset_in) begin
            caps <= BOP_CAPS_DEFAULT;
        end else if (hit_wr) begin
            caps <= req_in.wdata[BOP_IRMC_BIT -: 5];
        end
    end

    // clock accuracy, stored verbatim
    always_ff @(posedge ref_clk_in) begin
        if (hard_rst || soft_reset_in) begin
            accuracy <= BOP_ACC_DEFAULT;
        end else if (hit_wr) begin
            accuracy <= req_in.wdata[BOP_ACC_LSB +: 8];
        end
    end

    // request size: only global/hardware reset restores it
    always_ff @(posedge ref_clk_in) begin
        if (hard_rst) begin
            req_size <= BOP_REQ_DEFAULT;
        end else if (hit_wr) begin
            req_size <= req_in.wdata[BOP_REQ_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // generation: rom change arms, next bus reset advances
    always_ff @(posedge ref_clk_in) begin
        if (hard_rst || soft_reset_in) begin
            rom_dirty <= 1'b0;
        end else if (bus_reset_in) begin
            rom_dirty <= rom_changed_in; // change in same cycle not lost
        end else if (rom_changed_in) begin
            rom_dirty <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (hard_rst || soft_reset_in) begin
            generation <= BOP_GEN_DEFAULT;
        end else if (hit_wr) begin
            generation <= req_in.wdata[BOP_GEN_LSB +: 2];
        end else if (bus_reset_in && rom_dirty) begin
            generation <= generation + BOP_GEN_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assembled word; reserved and speed bits are constants
    always_comb begin
        cur_word = 32'h0000_0000;
        cur_word[BOP_IRMC_BIT -: 5]   = caps;
        cur_word[BOP_ACC_LSB +: 8]    = accuracy;
        cur_word[BOP_REQ_LSB +: 4]    = req_size;
        cur_word[BOP_GEN_LSB +: 2]    = generation;
        cur_word[BOP_SPD_LSB +: 3]    = BOP_SPD_CODE;
    end

    // registered host read data, zero off-map
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (req_in.rd && bop_hit(req_in.addr)) begin
            rdata_out <= cur_word;
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // remote-visible quadlet, registered copy
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            rom_quadlet_out <= 32'h0000_0000;
        end else begin
            rom_quadlet_out <= cur_word;
        end
    end

    // oversize block write flagged one cycle later, only while link_active_enable_in is set
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            ack_type_error_out <= 1'b0;
        end else begin
            ack_type_error_out <= blk_wr_in && link_active_enable_in &&
                ({16'h0000, blk_len_in} > bop_max_bytes(req_size));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks; reset terms sit in the antecedents as well, since a reset
    // seen at the starting edge changes state before the next sample

    // software keeps the size legal while the link runs
    size_min_a: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        link_active_enable_in |-> req_size >= BOP_REQ_MIN)
        else $error("request size below minimum");

    // reserved ranges never reach either read path
    rsvd_zero_a: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        rom_quadlet_out[26:24] == 3'h0 && rom_quadlet_out[11:8] == 4'h0 &&
        rom_quadlet_out[5:3] == 3'h0 && rdata_out[26:24] == 3'h0 &&
        rdata_out[11:8] == 4'h0 && rdata_out[5:3] == 3'h0)
        else $error("reserved bits not zero");

    // copy lags reset release by one edge, hence the past term
    speed_const_a: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        $past(nrst_in) |-> rom_quadlet_out[2:0] == BOP_SPD_CODE)
        else $error("link speed wrong");

    // soft reset alone must leave the size field alone
    soft_keep_a: assert property (
        @(posedge ref_clk_in) disable iff (hard_rst)
        soft_reset_in && !hard_rst && !hit_wr |=>
        req_size == $past(req_size))
        else $error("soft reset disturbed request size");

    // either hardware reset source restores the 2048 byte code
    hard_dflt_a: assert property (
        @(posedge ref_clk_in)
        hard_rst |=> req_size == BOP_REQ_DEFAULT)
        else $error("request size default wrong");

    // hardware reset clears every output on the next edge
    rst_out_a: assert property (
        @(posedge ref_clk_in)
        !nrst_in |=> rdata_out == 32'h0000_0000 && !ack_type_error_out &&
        rom_quadlet_out == 32'h0000_0000)
        else $error("outputs not cleared by reset");

    // accuracy byte reaches the remote copy two edges on
    acc_wr_a: assert property (
        @(posedge ref_clk_in) disable iff (hard_rst)
        hit_wr && !hard_rst && !soft_reset_in |=> ##1
        rom_quadlet_out[23:16] == $past(req_in.wdata[23:16], 2))
        else $error("accuracy not stored");

    // capability and power flags are plain storage
    caps_wr_a: assert property (
        @(posedge ref_clk_in) disable iff (hard_rst)
        hit_wr && !hard_rst && !soft_reset_in |=>
        caps == $past(req_in.wdata[31:27]))
        else $error("capability flags not stored");

    // size written by the host takes effect at once
    size_wr_a: assert property (
        @(posedge ref_clk_in) disable iff (hard_rst)
        hit_wr && !hard_rst |=>
        req_size == $past(req_in.wdata[BOP_REQ_LSB +: 4]))
        else $error("request size not stored");

    // a host read returns the word assembled at the strobe
    rd_word_a: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        nrst_in && req_in.rd && bop_hit(req_in.addr) |=>
        rdata_out == $past(cur_word))
        else $error("read data wrong");

    // no type error is raised while the link is down
    err_link_a: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !link_active_enable_in |=> !ack_type_error_out)
        else $error("type error with link disabled");

    // a dirty rom advances the count on the bus reset
    gen_step_a: assert property (
        @(posedge ref_clk_in) disable iff (hard_rst || soft_reset_in)
        !hard_rst && !soft_reset_in && bus_reset_in && rom_dirty &&
        !hit_wr |=> generation == $past(generation) + BOP_GEN_STEP)
        else $error("generation did not advance");

    // without bus reset or write the count holds
    gen_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (hard_rst || soft_reset_in)
        !hard_rst && !soft_reset_in && !bus_reset_in && !hit_wr |=>
        $stable(generation))
        else $error("generation changed unexpectedly");

    // main scenarios: host write, rom change then bus reset,
    // oversize block write, soft reset over a changed size
    wr_cov_c: cover property (@(posedge ref_clk_in) hit_wr);
    gen_cov_c: cover property (@(posedge ref_clk_in)
        rom_changed_in ##[1:8] bus_reset_in);
    err_cov_c: cover property (@(posedge ref_clk_in) ack_type_error_out);
    soft_cov_c: cover property (@(posedge ref_clk_in)
        soft_reset_in && req_size != BOP_REQ_DEFAULT);
endmodule

/* File: dv/bop_node_model.sv */
`timescale 1ns/100ps
// remote node on the serial bus: block writes and bus resets
module bop_node_model (
    input  wire logic        ref_clk_in,
    output logic             blk_wr_out,
    output logic [15:0]      blk_len_out,
    output logic             bus_reset_out
);
    initial begin
        blk_wr_out    = 1'b0;
        blk_len_out   = 16'h0000;
        bus_reset_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // length goes stale after the pulse so a late sample cannot match
    task automatic blk(input logic [15:0] len);
        @(posedge ref_clk_in);
        blk_wr_out  <= 1'b1;
        blk_len_out <= len;
        @(posedge ref_clk_in);
        blk_wr_out  <= 1'b0;
        blk_len_out <= ~len;
    endtask
    // one-cycle bus reset pulse
    task automatic bus_rst();
        @(posedge ref_clk_in);
        bus_reset_out <= 1'b1;
        @(posedge ref_clk_in);
        bus_reset_out <= 1'b0;
    endtask
endmodule

/* File: dv/bop_options_tb_top.sv */
`timescale 1ns/100ps
module bop_options_tb_top;
    import bop_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, global_power_on_reset = 1'b0, srst = 1'b0;
    logic lnk = 1'b0, romch = 1'b0, bwr, brst, err;
    logic [15:0] blen;
    logic [31:0] rdata, romq;
    bop_req_t    req = '0;
    int          bad_count = 0, checked = 0;
    always #4 clk = ~clk;
    bop_node_model bop_node_model_i (.ref_clk_in(clk), .blk_wr_out(bwr),
        .blk_len_out(blen), .bus_reset_out(brst));
    bop_options bop_options_i (.ref_clk_in(clk), .nrst_in(nrst),
        .global_power_on_reset_in(global_power_on_reset), .soft_reset_in(srst),
        .req_in(req), .link_active_enable_in(lnk),
        .rom_changed_in(romch), .bus_reset_in(brst), .blk_wr_in(bwr),
        .blk_len_in(blen), .rdata_out(rdata),
        .ack_type_error_out(err), .rom_quadlet_out(romq));
    ////////////////////////////////////////////////////////////////////
    task automatic chk32(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    // data lands on the edge that takes the read strobe, one cycle after it is driven
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk32(rdata, exp);
    endtask
    task automatic blk(input logic [15:0] n, input logic exp);
        bop_node_model_i.blk(n);
        #1 chk1(err, exp);
    endtask
    // one-cycle strobe on romch, srst or global_power_on_reset, picked by a bit mask
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        {global_power_on_reset, srst, romch} <= m;
        @(posedge clk);
        {global_power_on_reset, srst, romch} <= 3'h0;
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #100000 bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h20, 32'h0000_A002);
        blk(16'd2049, 1'b0);
        @(posedge clk);
        lnk <= 1'b1; // size left at its reset value first
        blk(16'd2048, 1'b0);
        blk(16'd2049, 1'b1);
        @(posedge clk);
        lnk <= 1'b0; // size changed only with link off
        wr(8'h20, 32'h0000_8000);
        lnk <= 1'b1;
        blk(16'd512, 1'b0);
        blk(16'd513, 1'b1);
        @(posedge clk);
        lnk <= 1'b0;
        wr(8'h20, 32'hFFFF_FFFF);
        @(posedge clk);
        #1 chk32(romq, 32'hF8FF_F0C2);
        rd(8'h20, 32'hF8FF_F0C2);
        wr(8'h24, 32'h0000_0000);
        rd(8'h24, 32'h0000_0000);
        rd(8'h20, 32'hF8FF_F0C2);
        // generation steps only after a rom change, then wraps 3 to 0
        bop_node_model_i.bus_rst();
        rd(8'h20, 32'hF8FF_F0C2);
        pulse(3'h1);
        bop_node_model_i.bus_rst();
        rd(8'h20, 32'hF8FF_F002);
        pulse(3'h2);
        rd(8'h20, 32'h0000_F002);
        wr(8'h20, 32'h0812_8040);
        rd(8'h20, 32'h0812_8042);
        pulse(3'h4);
        rd(8'h20, 32'h0000_A002);
        // mid-run hardware reset restores the size code as well
        wr(8'h20, 32'hFFFF_FFFF);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        rd(8'h20, 32'h0000_A002);
        tally_and_finish();
    end
endmodule
